// File: src/fcd_pkg.sv
// Constants, register map and encodings for the flash register bank and timebase divider
package fcd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_CLKDIV = 5'h00;
  localparam logic [4:0] IDX_SEC = 5'h01;
  localparam logic [4:0] IDX_CCOBIX = 5'h02;
  localparam logic [4:0] IDX_RSV0 = 5'h03;
  localparam logic [4:0] IDX_CNFG = 5'h04;
  localparam logic [4:0] IDX_ERCNFG = 5'h05;
  localparam logic [4:0] IDX_STAT = 5'h06;
  localparam logic [4:0] IDX_ERSTAT = 5'h07;
  localparam logic [4:0] IDX_PROT_RSV = 5'h08;
  localparam logic [4:0] IDX_DPROT = 5'h09;
  localparam logic [4:0] IDX_CCOBHI = 5'h0a;
  localparam logic [4:0] IDX_CCOBLO = 5'h0b;
  localparam logic [4:0] IDX_OPT = 5'h10;
  localparam logic [4:0] IDX_LAST = 5'h13;

  // Divider register fields
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_LOCK_BIT = 6;
  localparam int DIV_VALUE_MSB = 5;

  // Command status and error fields
  localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int STAT_ACCERR_BIT = 5;
  localparam int STAT_FPVIOL_BIT = 4;
  localparam int STAT_MGBUSY_BIT = 3;
  localparam int ERR_DFD_BIT = 1;
  localparam int ERR_SFD_BIT = 0;
  localparam int CNFG_IGNSF_BIT = 4;

  // Writable masks of configuration registers, and the security byte loaded on a fault
  localparam logic [7:0] CNFG_WMASK = 8'h93;
  localparam logic [7:0] ERCNFG_WMASK = 8'h03;
  localparam logic [7:0] CCOBIX_WMASK = 8'h07;
  localparam logic [7:0] SEC_FAULT_VALUE = 8'hff;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] CCOB_RESET = 16'h0000;
  localparam logic [5:0] DIV_RESET = 6'h00;

  // Global resource map
  localparam logic [17:0] MAP_DFLASH_LO = 18'h04400;
  localparam logic [17:0] MAP_DFLASH_HI = 18'h053ff;
  localparam logic [17:0] MAP_SCRATCH_LO = 18'h05800;
  localparam logic [17:0] MAP_SCRATCH_HI = 18'h05aff;
  localparam logic [17:0] MAP_RES_LO = 18'h04000;
  localparam logic [17:0] MAP_RES_HI = 18'h07fff;

  // Length of the controller reset sequence in bus cycles
  localparam int RESET_SEQ_CYCLES = 16;

  // Reset sequence states, Gray coded along boot, load, run
  typedef enum logic [1:0] {
    FCD_BOOT = 2'b00,
    FCD_LOAD = 2'b01,
    FCD_RUN = 2'b11
  } fcd_seq_t;

endpackage

// File: src/fcd_regs.sv
// Flash controller register bank with lockable timebase divider and resource map decode
`timescale 1ns/1ps
module fcd_regs import fcd_pkg::*; #(
  parameter int ADR_W = 8,
  parameter int SEQ_CYCLES = RESET_SEQ_CYCLES,
  parameter int DIV_W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmd_active,
  input wire logic [7:0] sec_byte,
  input wire logic sec_fault,
  input wire logic [7:0] prot_byte,
  input wire logic [7:0] opt_byte,
  input wire logic [2:0] mgr_status,
  input wire logic acc_err_set,
  input wire logic prot_viol_set,
  input wire logic dbl_fault_set,
  input wire logic sgl_fault_set,
  input wire logic [17:0] global_addr,
  output logic command_complete_flag,
  output logic timebase_tick,
  output logic divider_loaded_flag,
  output logic [7:0] cnfg_out,
  output logic [7:0] ercnfg_out,
  output logic dflash_sel,
  output logic scratch_sel,
  output logic reserved_sel
);

  localparam logic [5:0] SEQ_LAST = 6'(SEQ_CYCLES - 1);

  fcd_seq_t seq_q;
  logic [5:0] seq_cnt_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic loaded_q;
  logic lock_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] tb_cnt_q;
  logic tick_q;
  logic command_complete_flag_q;
  logic [7:0] sec_q;
  logic [7:0] prot_q;
  logic [7:0] opt_q;
  logic [7:0] ccobix_q;
  logic [7:0] cnfg_q;
  logic [7:0] ercnfg_q;
  logic accerr_q;
  logic fpviol_q;
  logic dfd_q;
  logic sfd_q;
  logic [15:0] ccob_q [8];
  logic dflash_q;
  logic scratch_q;
  logic reserved_q;

  logic req;
  logic [4:0] idx;
  logic mapped;
  logic wr_commit;
  logic wr_lane;
  logic [7:0] wbyte;
  logic [7:0] stat_view;
  logic [7:0] rd_byte;

  // Request decode; registers use the low byte lane of each word
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[6:2];
  assign mapped = (wb_adr_i[ADR_W-1:7] == '0) && (wb_adr_i[1:0] == 2'b00)
                  && (idx <= IDX_LAST);
  assign wr_lane = wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  // Writes land on the edge where the master samples ack, never earlier
  assign wr_commit = req & ack_q & wb_we_i & wr_lane & mapped;

  // Controller reset sequence: boot, then load nonvolatile bytes, then run
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q <= FCD_BOOT;
      seq_cnt_q <= 6'h00;
    end else begin
      case (seq_q)
        FCD_BOOT: begin
          if (seq_cnt_q == SEQ_LAST) begin
            seq_q <= FCD_LOAD;
          end else begin
            seq_cnt_q <= seq_cnt_q + 6'h01;
          end
        end
        FCD_LOAD: seq_q <= FCD_RUN;
        FCD_RUN: seq_q <= FCD_RUN;
        default: seq_q <= FCD_BOOT;
      endcase
    end
  end

  // Nonvolatile images are caught by a clocked load after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_q <= REG_RESET;
      prot_q <= REG_RESET;
      opt_q <= REG_RESET;
    end else if (seq_q == FCD_LOAD) begin
      sec_q <= sec_fault ? SEC_FAULT_VALUE : sec_byte; // Fault leaves part secured
      prot_q <= prot_byte;
      opt_q <= opt_byte;
    end
  end

  // Command complete is low during the reset sequence and any active command
  always_ff @(posedge clk) begin
    if (rst) begin
      command_complete_flag_q <= 1'b0;
    end else begin
      command_complete_flag_q <= (seq_q == FCD_RUN) & ~cmd_active;
    end
  end

  // Divider register; no command-state gate so it is writable in reset sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_q <= 1'b0;
      lock_q <= 1'b0;
      div_q <= DIV_RESET;
    end else if (wr_commit && idx == IDX_CLKDIV) begin
      loaded_q <= 1'b1; // Any write marks the divider loaded
      lock_q <= lock_q | wbyte[DIV_LOCK_BIT]; // Write-once-high
      if (!lock_q) begin
        div_q <= wbyte[DIV_VALUE_MSB:0];
      end // Locked: value kept, flags still update
    end
  end

  // Timebase: one tick every divide value plus one bus clocks once loaded
  always_ff @(posedge clk) begin
    if (rst) begin
      tb_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (!loaded_q) begin
      tb_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tb_cnt_q >= div_q) begin
      tb_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tb_cnt_q <= tb_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Plain configuration registers; unimplemented bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      ccobix_q <= REG_RESET;
      cnfg_q <= REG_RESET;
      ercnfg_q <= REG_RESET;
    end else if (wr_commit) begin
      case (idx)
        IDX_CCOBIX: ccobix_q <= wbyte & CCOBIX_WMASK;
        IDX_CNFG: cnfg_q <= wbyte & CNFG_WMASK;
        IDX_ERCNFG: ercnfg_q <= wbyte & ERCNFG_WMASK;
        default: ccobix_q <= ccobix_q;
      endcase
    end
  end

  // Command object words, selected by the index register
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        ccob_q[i] <= CCOB_RESET;
      end
    end else if (wr_commit && idx == IDX_CCOBHI) begin
      ccob_q[ccobix_q[2:0]][15:8] <= wbyte;
    end else if (wr_commit && idx == IDX_CCOBLO) begin
      ccob_q[ccobix_q[2:0]][7:0] <= wbyte;
    end
  end

  // Sticky error flags, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      accerr_q <= 1'b0;
      fpviol_q <= 1'b0;
      dfd_q <= 1'b0;
      sfd_q <= 1'b0;
    end else begin
      accerr_q <= acc_err_set | (accerr_q & ~(wr_commit && idx == IDX_STAT
                  && wbyte[STAT_ACCERR_BIT]));
      fpviol_q <= prot_viol_set | (fpviol_q & ~(wr_commit && idx == IDX_STAT
                  && wbyte[STAT_FPVIOL_BIT]));
      dfd_q <= dbl_fault_set | (dfd_q & ~(wr_commit && idx == IDX_ERSTAT
               && wbyte[ERR_DFD_BIT]));
      // Single faults go unreported while the ignore bit is set
      sfd_q <= (sgl_fault_set & ~cnfg_q[CNFG_IGNSF_BIT]) | (sfd_q & ~(wr_commit
               && idx == IDX_ERSTAT && wbyte[ERR_SFD_BIT]));
    end
  end

  // Status view assembled from the flag and manager inputs
  assign stat_view = {command_complete_flag_q, 1'b0, accerr_q, fpviol_q, mgr_status[2], 1'b0,
                      mgr_status[1:0]};

  // Read multiplexer; reserved and unmapped locations read zero
  always_comb begin
    rd_byte = 8'h00;
    if (mapped) begin
      case (idx)
        IDX_CLKDIV: rd_byte = {loaded_q, lock_q, div_q};
        IDX_SEC: rd_byte = sec_q;
        IDX_CCOBIX: rd_byte = ccobix_q;
        IDX_CNFG: rd_byte = cnfg_q;
        IDX_ERCNFG: rd_byte = ercnfg_q;
        IDX_STAT: rd_byte = stat_view;
        IDX_ERSTAT: rd_byte = {6'h00, dfd_q, sfd_q};
        IDX_DPROT: rd_byte = prot_q;
        IDX_CCOBHI: rd_byte = ccob_q[ccobix_q[2:0]][15:8];
        IDX_CCOBLO: rd_byte = ccob_q[ccobix_q[2:0]][7:0];
        IDX_OPT: rd_byte = opt_q;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) begin
        rdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // Global resource decode, registered for timing
  always_ff @(posedge clk) begin
    if (rst) begin
      dflash_q <= 1'b0;
      scratch_q <= 1'b0;
      reserved_q <= 1'b0;
    end else begin
      dflash_q <= (global_addr >= MAP_DFLASH_LO) && (global_addr <= MAP_DFLASH_HI);
      scratch_q <= (global_addr >= MAP_SCRATCH_LO) && (global_addr <= MAP_SCRATCH_HI);
      reserved_q <= (global_addr >= MAP_RES_LO) && (global_addr <= MAP_RES_HI)
                    && !((global_addr >= MAP_DFLASH_LO) && (global_addr <= MAP_DFLASH_HI))
                    && !((global_addr >= MAP_SCRATCH_LO) && (global_addr <= MAP_SCRATCH_HI));
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign command_complete_flag = command_complete_flag_q;
  assign timebase_tick = tick_q;
  assign divider_loaded_flag = loaded_q;
  assign cnfg_out = cnfg_q;
  assign ercnfg_out = ercnfg_q;
  assign dflash_sel = dflash_q;
  assign scratch_sel = scratch_q;
  assign reserved_sel = reserved_q;

endmodule

// File: sim/fcd_regs_checker.sv
// Port-level assertions for the flash register bank and timebase divider
`timescale 1ns/1ps
module fcd_regs_checker #(
  parameter int ADR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cmd_active,
  input wire logic [17:0] global_addr,
  input wire logic command_complete_flag,
  input wire logic timebase_tick,
  input wire logic divider_loaded_flag,
  input wire logic dflash_sel,
  input wire logic scratch_sel,
  input wire logic reserved_sel
);
  logic [4:0] idx;
  logic rsv, in_df, in_sc, in_rs;
  // Slot decode; misaligned and high addresses count as reserved
  assign idx = wb_adr_i[6:2];
  assign rsv = wb_adr_i[7] | (|wb_adr_i[1:0]) | (idx > 5'h10) | (idx == 5'h03) |
    (idx == 5'h08) | (idx[4:2] == 3'b011);
  // Expected map decode of the resource window
  assign in_df = (global_addr >= 18'h04400) && (global_addr <= 18'h053ff);
  assign in_sc = (global_addr >= 18'h05800) && (global_addr <= 18'h05aff);
  assign in_rs = (global_addr >= 18'h04000) && (global_addr <= 18'h07fff) && !in_df && !in_sc;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_div_wr;
    wb_ack_o && wb_we_i && wb_sel_i[0] && (idx == 5'h00) && !rsv;
  endsequence

  property p_ack_one;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one pulse after request");
  property p_hi_zero;
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000);
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bytes not zero");
  property p_rsv_zero;
    wb_ack_o && !wb_we_i && rsv |-> (wb_dat_o == 32'h00000000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved slot read nonzero");
  property p_command_complete_flag_low;
    cmd_active |=> !command_complete_flag;
  endproperty
  a_command_complete_flag_low: assert property (p_command_complete_flag_low) else $error("complete flag high in command");
  property p_ld_set;
    s_div_wr |=> divider_loaded_flag;
  endproperty
  a_ld_set: assert property (p_ld_set) else $error("loaded flag not set by write");
  property p_ld_hold;
    divider_loaded_flag |=> divider_loaded_flag;
  endproperty
  a_ld_hold: assert property (p_ld_hold) else $error("loaded flag dropped");
  property p_ld_read;
    wb_ack_o && !wb_we_i && (idx == 5'h00) && !rsv |-> (wb_dat_o[7] == divider_loaded_flag);
  endproperty
  a_ld_read: assert property (p_ld_read) else $error("divider bit7 differs from flag");
  property p_tick_ld;
    timebase_tick |-> divider_loaded_flag;
  endproperty
  a_tick_ld: assert property (p_tick_ld) else $error("tick before divider loaded");
  // Decode is one cycle late, so compare only while the address holds still
  property p_map;
    $stable(global_addr) && !$past(rst) |->
      ({dflash_sel, scratch_sel, reserved_sel} == {in_df, in_sc, in_rs});
  endproperty
  a_map: assert property (p_map) else $error("resource decode wrong");
endmodule

bind fcd_regs fcd_regs_checker #(.ADR_W(ADR_W)) u_fcd_regs_checker (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .cmd_active, .global_addr,
  .command_complete_flag, .timebase_tick, .divider_loaded_flag, .dflash_sel, .scratch_sel,
  .reserved_sel);

// File: sim/tb.sv
// Self-checking bench for the flash register bank over classic Wishbone
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cmd = 1'b0, aerr = 1'b0;
  logic [7:0] adr = 8'h00, nv = 8'h3c;
  logic [3:0] sel = 4'h0;
  logic [2:0] mgr = 3'h0;
  logic [31:0] dat = 32'h0, rdat, dout;
  logic [17:0] ga = 18'h0;
  logic ack, ccf, tick, ld, dsel, ssel, rsel;
  logic [7:0] cfo, efo;
  int n_fail = 0, samples_checked = 0, cyc_cnt = 0, k;
  logic [7:0] ra [8] = '{8'h0c, 8'h20, 8'h30, 8'h4c, 8'h50, 8'h7c, 8'h01, 8'h80};
  logic [17:0] ma [8] = '{18'h04400, 18'h053ff, 18'h05400, 18'h05800, 18'h05aff,
    18'h05b00, 18'h03fff, 18'h08000};
  logic [2:0] me [8] = '{3'h4, 3'h4, 3'h1, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0};

  always #12.5 clk = ~clk;

  // Five fault and image inputs are held quiet; their logic is outside this bench
  fcd_regs u_fcd_regs (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmd_active(cmd), .sec_byte(nv), .sec_fault(1'b0), .prot_byte(8'h00), .opt_byte(nv),
    .mgr_status(mgr), .acc_err_set(aerr), .prot_viol_set(1'b0), .dbl_fault_set(1'b0),
    .sgl_fault_set(1'b0), .global_addr(ga), .command_complete_flag(ccf),
    .timebase_tick(tick), .divider_loaded_flag(ld), .cnfg_out(cfo), .ercnfg_out(efo),
    .dflash_sel(dsel), .scratch_sel(ssel), .reserved_sel(rsel));

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A hung handshake ends here rather than spinning forever
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; request held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    dat <= {24'h0, d};
    sel <= 4'h1;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    dout = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, e}, dout);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask

  initial begin
    do_reset();
    rdchk(8'h00, 8'h00);
    xfer(1'b1, 8'h00, 8'h03);
    rdchk(8'h00, 8'h83);
    k = 0;
    while (tick !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    k = 1;
    while (tick !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk("tick period", 32'd4, k);
    xfer(1'b1, 8'h00, 8'h45);
    rdchk(8'h00, 8'hc5);
    xfer(1'b1, 8'h00, 8'h0a);
    rdchk(8'h00, 8'hc5);
    $display("test divider done");
    // Reserved, unmapped and misaligned places all swallow writes
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, ra[i], 8'hff);
      rdchk(ra[i], 8'h00);
    end
    xfer(1'b1, 8'h28, 8'h5a);
    rdchk(8'h28, 8'h5a);
    xfer(1'b1, 8'h40, 8'hff);
    rdchk(8'h40, 8'h3c);
    // Configuration bytes keep only their implemented bits, on the bus and on the pins
    xfer(1'b1, 8'h10, 8'hff);
    rdchk(8'h10, 8'h93);
    chk("cnfg out", 32'h93, {24'h0, cfo});
    xfer(1'b1, 8'h14, 8'hff);
    rdchk(8'h14, 8'h03);
    chk("ercnfg out", 32'h03, {24'h0, efo});
    k = 0;
    while (ccf !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    mgr <= 3'h5;
    @(posedge clk);
    aerr <= 1'b1;
    @(posedge clk);
    aerr <= 1'b0;
    rdchk(8'h18, 8'ha9);
    xfer(1'b1, 8'h18, 8'h20);
    rdchk(8'h18, 8'h89);
    cmd <= 1'b1;
    repeat (2) @(posedge clk);
    chk("complete flag", 32'h0, {31'h0, ccf});
    rdchk(8'h18, 8'h09); // only reads while the command runs
    cmd <= 1'b0;
    $display("test status done");
    for (int i = 0; i < 8; i++) begin
      ga <= ma[i];
      repeat (2) @(posedge clk);
      chk("map", {29'h0, me[i]}, {29'h0, dsel, ssel, rsel});
    end
    do_reset();
    rdchk(8'h00, 8'h00);
    // A 40 MHz bus clock sits in the band one past 0x26, so software loads 0x27
    xfer(1'b1, 8'h00, 8'h27);
    rdchk(8'h00, 8'ha7);
    $display("test map and reset done");
    tally_and_finish();
  end
endmodule
